// File: hw/txs_consts.svh
/*
  Constants for the transmit start and result block: register offsets,
  field positions and reset values.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef TXS_CONSTS_SVH
`define TXS_CONSTS_SVH

`define TXS_RESULT_OFS      8'h60
`define TXS_LAUNCH_OFS      8'h5c
`define TXS_RESULT_RST      32'h0000_0000
`define TXS_LAUNCH_RST      12'h000
`define TXS_BIT_FAULT       0
`define TXS_BIT_LATE        2
`define TXS_BIT_LIMIT       3
`define TXS_BIT_STARVE      4
`define TXS_BIT_NOTIFY      6
`define TXS_BIT_DONE        7
`define TXS_TAG_LSB         16
`define TXS_LAUNCH_W        12
`define TXS_SLOT_BITS       4096
`define TXS_COLLIDE_MAX     16

`endif

// File: hw/txs_pkg.sv
/*
  Types shared by the transmit start and result block.
  Assumes txs_consts.svh is on the include path.
*/
`default_nettype none
`include "txs_consts.svh"

package txs_pkg;

  // One word of frame data headed for the wire
  typedef struct packed {
    logic        last;
    logic [31:0] data;
  } txs_word_t;

  // Per-frame control captured when the descriptor is fetched
  typedef struct packed {
    logic        ip_sum_insert_en;
    logic        tcp_sum_insert_en;
    logic        udp_sum_insert_en;
    logic        tx_notify_bit;
    logic [15:0] tx_frame_tag;
  } txs_ctrl_t;

  // Outcome reported by the transmit MAC at frame end
  typedef struct packed {
    logic late;
    logic limit;
    logic starve;
  } txs_outcome_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SEND,
    ST_HALT
  } txs_state_t;

endpackage

`default_nettype wire

// File: hw/txs_skid.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides share clk and the synchronous reset.
*/
`default_nettype none

module txs_skid
  import txs_pkg::*;
#(
  parameter int WIDTH = 33
)
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Elaboration check: an empty word cannot be stored
  if (WIDTH < 1)
  begin : g_width_check
    $error("txs_skid: WIDTH must be positive");
  end

  // Honest flags: ready only while a slot is free
  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];

  // Pointers and occupancy; flush empties without touching storage
  always_ff @(posedge clk)
  begin
    if (sys_rst || flush)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage
  always_ff @(posedge clk)
  begin
    if (push) mem_q[wr_q] <= in_data;
  end

  a_skid_no_overflow: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_q <= 2'd2) else $error("buffer count over two");
endmodule

`default_nettype wire

// File: hw/txs_tx_start.sv
/*
  Transmit launch control and per-frame result word.
  Assumes the transmit FIFO holds one frame at a time from the DMA side,
  with a frame's control presented at its start, and the transmit MAC
  on the same clock reporting outcome once per frame.
*/
`default_nettype none
`include "txs_consts.svh"

module txs_tx_start
  import txs_pkg::*;
#(
  parameter int DEPTH = 512
)
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_rd,
  input  wire logic               reg_wr,
  input  wire logic [31:0]        reg_wdata,
  output logic      [31:0]        reg_rdata,
  // Control bits from the MAC and chip control registers
  input  wire logic               tx_path_enable_set,
  input  wire logic               tx_path_reset,
  input  wire logic               fifo_flush,
  // Frame control from the descriptor fetch
  input  wire logic               ctrl_valid,
  input  wire txs_pkg::txs_ctrl_t ctrl_in,
  // DMA side of the transmit FIFO
  input  wire logic               dma_valid,
  output logic                    dma_ready,
  input  wire txs_pkg::txs_word_t dma_word,
  // Transmit MAC side
  output logic                    mac_valid,
  input  wire logic               mac_ready,
  output txs_pkg::txs_word_t      mac_word,
  output logic                    mac_rewind,
  input  wire logic               mac_end,
  input  wire txs_pkg::txs_outcome_t mac_outcome,
  output logic                    tx_running
);
  import txs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // Elaboration check: the wrapping pointers need a power-of-two depth
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("txs_tx_start: DEPTH must be a power of two, at least 4");
  end

  txs_state_t           state_q, state_d;
  txs_word_t            mem_q [DEPTH];
  logic [AW:0]          wr_q, rd_q, start_q;
  logic [AW:0]          fill_q;
  logic                 whole_q;
  txs_ctrl_t            ctrl_q;
  logic [`TXS_LAUNCH_W-1:0] launch_q;
  logic [31:0]          result_q;
  logic                 halted_q;

  // Decoding and status
  wire sel_result = (reg_addr == `TXS_RESULT_OFS);
  wire sel_launch = (reg_addr == `TXS_LAUNCH_OFS);
  wire rd_result  = reg_rd && sel_result;
  wire fifo_full  = ((wr_q - start_q) == DEPTH[AW:0]);
  wire fifo_has   = (rd_q != wr_q);
  wire sum_ins    = ctrl_q.ip_sum_insert_en || ctrl_q.tcp_sum_insert_en ||
                    ctrl_q.udp_sum_insert_en;
  wire level_met  = (fill_q > {{(AW+1){1'b0}}, launch_q});
  wire go         = sum_ins ? whole_q : (level_met || whole_q);
  wire fault      = mac_outcome.late || mac_outcome.limit ||
                    mac_outcome.starve;

  // Buffer between FIFO read port and MAC, so a MAC stall loses nothing
  logic      buf_ready;
  logic      rd_fire;
  txs_word_t rd_word_q;
  logic      rd_vld_q;

  assign dma_ready = ~fifo_full && ~halted_q && (state_q != ST_HALT);
  assign rd_fire   = (state_q == ST_SEND) && fifo_has && (~rd_vld_q || buf_ready);
  assign tx_running = (state_q == ST_SEND);

  txs_skid #(
    .WIDTH ($bits(txs_word_t))
  ) u_skid (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (mac_rewind),
    .in_valid  (rd_vld_q),
    .in_ready  (buf_ready),
    .in_data   (rd_word_q),
    .out_valid (mac_valid),
    .out_ready (mac_ready),
    .out_data  (mac_word)
  );

  // FIFO storage; written only while not halted
  always_ff @(posedge clk)
  begin
    if (dma_valid && dma_ready) mem_q[wr_q[AW-1:0]] <= dma_word;
  end

  // Read stage feeding the buffer
  always_ff @(posedge clk)
  begin
    if (sys_rst || mac_rewind)
      rd_vld_q <= 1'b0;
    else if (rd_fire)
    begin
      rd_word_q <= mem_q[rd_q[AW-1:0]];
      rd_vld_q  <= 1'b1;
    end
    else if (buf_ready)
      rd_vld_q <= 1'b0;
  end

  // Frame state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (ctrl_valid) state_d = ST_WAIT;
      ST_WAIT:
        if (go) state_d = ST_SEND;
      ST_SEND:
        if (mac_end) state_d = ST_HALT;
      // A frame kept after a late collision goes back to waiting for launch
      ST_HALT:
        if (tx_path_enable_set && !halted_q) state_d = fifo_has ? ST_WAIT : ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
    if (mac_end && !fault) state_d = ST_IDLE;
  end

  // Pointers: late collision rewinds, limit drops, success retires
  always_ff @(posedge clk)
  begin
    if (sys_rst || fifo_flush || tx_path_reset)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      start_q <= '0;
      fill_q  <= '0;
      whole_q <= 1'b0;
    end
    else
    begin
      if (dma_valid && dma_ready)
      begin
        wr_q   <= wr_q + 1'b1;
        fill_q <= fill_q + 1'b1;
        if (dma_word.last) whole_q <= 1'b1;
      end
      if (rd_fire) rd_q <= rd_q + 1'b1;
      if (mac_end && mac_outcome.late)
        rd_q <= start_q;
      else if (mac_end)
      begin
        start_q <= wr_q;
        rd_q    <= wr_q;
        fill_q  <= '0;
        whole_q <= 1'b0;
      end
    end
  end

  assign mac_rewind = mac_end && fault;

  // Control, launch level, halt
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q  <= ST_IDLE;
      ctrl_q   <= '0;
      launch_q <= `TXS_LAUNCH_RST;
      halted_q <= 1'b0;
    end
    else
    begin
      state_q <= (tx_path_reset || fifo_flush) && state_q != ST_HALT ? ST_IDLE : state_d;
      if (ctrl_valid && state_q == ST_IDLE) ctrl_q <= ctrl_in;
      if (reg_wr && sel_launch) launch_q <= reg_wdata[`TXS_LAUNCH_W-1:0];
      if (mac_end && mac_outcome.starve)
        halted_q <= 1'b1;
      else if (tx_path_reset)
        halted_q <= 1'b0;
    end
  end

  // Result word: frame end wins over a read-clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      result_q <= `TXS_RESULT_RST;
    else if (mac_end)
    begin
      result_q                    <= '0;
      result_q[`TXS_BIT_FAULT]    <= fault;
      result_q[`TXS_BIT_LATE]     <= mac_outcome.late;
      result_q[`TXS_BIT_LIMIT]    <= mac_outcome.limit;
      result_q[`TXS_BIT_STARVE]   <= mac_outcome.starve;
      result_q[`TXS_BIT_NOTIFY]   <= ctrl_q.tx_notify_bit;
      result_q[`TXS_BIT_DONE]     <= 1'b1;
      result_q[31:`TXS_TAG_LSB]   <= ctrl_q.tx_frame_tag;
    end
    else if (rd_result)
      result_q <= '0;
  end

  // Read data, registered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (rd_result)
      reg_rdata <= result_q;
    else if (reg_rd && sel_launch)
      reg_rdata <= {20'h0_0000, launch_q};
    else if (reg_rd)
      reg_rdata <= '0;
  end

  // Named steps of the frame-end behaviours
  sequence s_frame_end;
    mac_end;
  endsequence

  sequence s_late_end;
    mac_end && mac_outcome.late;
  endsequence

  sequence s_limit_end;
    mac_end && mac_outcome.limit && !mac_outcome.late;
  endsequence

  sequence s_starve_end;
    mac_end && mac_outcome.starve;
  endsequence

  sequence s_resume;
    state_q == ST_HALT && tx_path_enable_set && !halted_q && fifo_has;
  endsequence

  // Launch: level or whole frame; checksum frames wait for the last word
  a_start_level: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_WAIT && state_d == ST_SEND && !sum_ins) |->
      (fill_q > {{(AW+1){1'b0}}, launch_q}) || whole_q)
    else $error("frame started below launch level");

  a_sum_whole: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_WAIT && sum_ins && !whole_q) |=> state_q != ST_SEND)
    else $error("checksum frame started early");

  // Result word: read-clear, summary bit and per-frame update
  a_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_result && !mac_end) |=> result_q == 32'h0 && reg_rdata == $past(result_q))
    else $error("result word not cleared on read");

  a_fault_sum: assert property (@(posedge clk) disable iff (sys_rst)
    result_q[0] == (result_q[2] || result_q[3] || result_q[4]))
    else $error("fault summary mismatch");

  a_late_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_frame_end |=> result_q[2] == $past(mac_outcome.late) && result_q[1] == 1'b0)
    else $error("late collision flag wrong");

  a_done_tag: assert property (@(posedge clk) disable iff (sys_rst)
    s_frame_end |=> result_q[7] && result_q[31:16] == $past(ctrl_q.tx_frame_tag)
      && result_q[6] == $past(ctrl_q.tx_notify_bit))
    else $error("result fields not updated");

  // Fault recovery: keep and resume, drop and stop, halt on underrun
  a_late_rewind: assert property (@(posedge clk) disable iff (sys_rst || fifo_flush
    || tx_path_reset) s_late_end |=> rd_q == $past(start_q))
    else $error("late collision frame not kept");

  a_late_resume: assert property (@(posedge clk) disable iff (sys_rst || fifo_flush
    || tx_path_reset) s_resume |=> state_q == ST_WAIT)
    else $error("kept frame not resumed on enable");

  a_limit_drop: assert property (@(posedge clk) disable iff (sys_rst || fifo_flush
    || tx_path_reset) s_limit_end |=> start_q == $past(wr_q) && state_q == ST_HALT)
    else $error("limit frame not dropped");

  a_starve_halt: assert property (@(posedge clk) disable iff (sys_rst)
    s_starve_end |=> halted_q && !dma_ready)
    else $error("underrun did not halt");
endmodule

`default_nettype wire

// File: test/tx_start_and_status_test.sv
/*
  Self-checking bench for the transmit start and result block.
  Assumes the package, design and MAC model compile first.
*/
`default_nettype none
module tx_start_and_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import txs_pkg::*;
  logic         clk;
  logic         sys_rst;
  logic [7:0]   reg_addr;
  logic         reg_rd;
  logic         reg_wr;
  logic [31:0]  reg_wdata;
  logic [31:0]  reg_rdata;
  logic         en_set;
  logic         tx_rst;
  logic         flush;
  logic         ctrl_valid;
  txs_ctrl_t    ctrl_in;
  logic         dma_valid;
  logic         dma_ready;
  txs_word_t    dma_word;
  logic         mac_valid;
  logic         mac_ready;
  txs_word_t    mac_word;
  logic         mac_end;
  txs_outcome_t mac_outcome;
  logic         tx_running;
  logic         slow;
  txs_outcome_t fate;
  int           words;
  int           w0;
  int           fails = 0;
  int           num_checks = 0;
  int           cycles = 0;
  logic [31:0]  v;
  logic         mac_rewind;
  logic [31:0]  last_word = 32'h0;
  int           rewinds = 0;
  int           r0;

  txs_tx_start u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_path_enable_set(en_set), .tx_path_reset(tx_rst), .fifo_flush(flush),
    .ctrl_valid(ctrl_valid), .ctrl_in(ctrl_in), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_word(dma_word), .mac_valid(mac_valid),
    .mac_ready(mac_ready), .mac_word(mac_word), .mac_rewind(mac_rewind), .mac_end(mac_end),
    .mac_outcome(mac_outcome), .tx_running(tx_running));
  txs_mac_model u_mac (.clk(clk), .sys_rst(sys_rst), .slow(slow), .fate(fate),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_word(mac_word),
    .mac_end(mac_end), .mac_outcome(mac_outcome), .words(words));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, far above what the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      conclude();
    end
  end

  // What the MAC side sees: rewind pulses and the last word of each frame
  always @(posedge clk)
  begin
    if (mac_rewind === 1'b1)
      rewinds <= rewinds + 1;
    if (mac_valid === 1'b1 && mac_ready === 1'b1 && mac_word.last === 1'b1)
      last_word <= mac_word.data;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // One register access; idle cycle after so strobes never re-rise in one step
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    step();
    v         = reg_rdata;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    step();
  endtask

  // Pulse of {flush, transmit reset, enable}
  task automatic ctl(input logic [2:0] p);
    {flush, tx_rst, en_set} = p;
    step();
    {flush, tx_rst, en_set} = 3'b000;
    step();
  endtask

  // Words from..to-1 of a frame of n; control word goes first
  task automatic load(input logic [3:0] f, input logic [15:0] tag, input int from,
                      input int to, input int n);
    if (from == 0)
    begin
      ctrl_in    = {f, tag};
      ctrl_valid = 1'b1;
      step();
      ctrl_valid = 1'b0;
    end
    for (int i = from; i < to; i++)
    begin
      dma_valid = 1'b1;
      dma_word  = {i == n - 1, tag, 16'(i)};
      // Ready is judged settled, before the edge that takes the word
      for (int j = 0; j < 100; j++)
      begin
        if (dma_ready === 1'b1)
          break;
        step();
      end
      step();
    end
    dma_valid = 1'b0;
  endtask

  task automatic finish_frame();
    for (int i = 0; i < 300; i++)
    begin
      step();
      if (mac_end === 1'b1)
        break;
    end
    check(mac_end === 1'b1, "no frame end");
    step(2);
  endtask

  function automatic logic [31:0] expect_word(logic [15:0] t, logic n, txs_outcome_t o);
    return {t, 8'h00, 1'b1, n, 1'b0, o.starve, o.limit, o.late, 1'b0, |o};
  endfunction

  task automatic fault_frame(input txs_outcome_t o, input logic [15:0] tag);
    fate = o;
    r0   = rewinds;
    load(4'h1, tag, 0, 4, 4);
    finish_frame();
    fate = 3'b000;
    check(tx_running === 1'b0, "still running");
    check(rewinds - r0 == ((o != 3'b000) ? 1 : 0), "rewind pulse");
    check(last_word === {tag, 16'h0003}, "last word data");
    bus(8'h60, 32'h0, 1'b0);
    check(v === expect_word(tag, 1'b1, o), "result fields");
  endtask

  task automatic t_regs();
    bus(8'h60, 32'h0, 1'b0);
    check(v === 32'h0000_0000, "result reset");
    bus(8'h60, 32'hffff_ffff, 1'b1);
    bus(8'h60, 32'h0, 1'b0);
    check(v === 32'h0000_0000, "result took write");
    bus(8'h5c, 32'h0000_0abc, 1'b1);
    bus(8'h5c, 32'h0, 1'b0);
    check(v === 32'h0000_0abc, "level readback");
    bus(8'h44, 32'h0, 1'b0);
    check(v === 32'h0, "unmapped read");
    $display("Test regs done");
  endtask

  task automatic t_launch();
    bus(8'h5c, 32'h0000_0003, 1'b1);
    w0 = words;
    load(4'h1, 16'h1a2b, 0, 3, 6);
    step(8);
    check(tx_running === 1'b0 && words == w0, "start at level");
    load(4'h1, 16'h1a2b, 3, 4, 6);
    step(4);
    check(tx_running === 1'b1, "no start past level");
    load(4'h1, 16'h1a2b, 4, 6, 6);
    finish_frame();
    check(words - w0 == 6, "word count");
    check(last_word === 32'h1a2b_0005, "last word data");
    bus(8'h60, 32'h0, 1'b0);
    check(v === expect_word(16'h1a2b, 1'b1, 3'b000), "result ok");
    bus(8'h60, 32'h0, 1'b0);
    check(v === 32'h0, "not cleared");
    $display("Test launch done");
  endtask

  task automatic t_sum();
    bus(8'h5c, 32'h0, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      w0 = words;
      load(4'h8 >> k, 16'h0b00 + 16'(k), 0, 3, 4);
      step(8);
      check(tx_running === 1'b0 && words == w0, "sum frame early");
      load(4'h8 >> k, 16'h0b00 + 16'(k), 3, 4, 4);
      finish_frame();
      bus(8'h60, 32'h0, 1'b0);
      check(v === expect_word(16'h0b00 + 16'(k), 1'b0, 3'b000), "sum result");
    end
    $display("Test checksum done");
  endtask

  // Receiver stalls every other cycle until the limit frame, so the two-entry buffer fills
  task automatic t_faults();
    slow = 1'b1;
    fault_frame(3'b100, 16'h0c01);
    w0 = words;
    step(10);
    check(words == w0, "sent while halted");
    ctl(3'b001);
    finish_frame();
    check(words - w0 == 4, "no resend");
    check(last_word === 32'h0c01_0003, "resent data");
    fault_frame(3'b100, 16'h0c02);
    ctl(3'b100);
    ctl(3'b001);
    w0 = words;
    step(12);
    check(words == w0, "flushed frame sent");
    slow = 1'b0;
    fault_frame(3'b010, 16'h0d01);
    ctl(3'b001);
    step(10);
    check(words == w0 + 4, "dropped frame sent");
    fault_frame(3'b000, 16'h0d01);
    fault_frame(3'b001, 16'h0e01);
    check(dma_ready === 1'b0, "fifo open");
    ctl(3'b010);
    ctl(3'b001);
    fault_frame(3'b000, 16'h0e02);
    load(4'h0, 16'h0f01, 0, 2, 2);
    finish_frame();
    load(4'h0, 16'h0f02, 0, 2, 2);
    finish_frame();
    bus(8'h60, 32'h0, 1'b0);
    check(v === expect_word(16'h0f02, 1'b0, 3'b000), "older kept");
    $display("Test faults done");
  endtask

  initial
  begin
    sys_rst    = 1'b1;
    reg_addr   = 8'h00;
    reg_rd     = 1'b0;
    reg_wr     = 1'b0;
    reg_wdata  = 32'h0;
    {flush, tx_rst, en_set} = 3'b000;
    ctrl_valid = 1'b0;
    ctrl_in    = '0;
    dma_valid  = 1'b0;
    dma_word   = '0;
    slow       = 1'b0;
    fate       = 3'b000;
    step(10);
    sys_rst    = 1'b0;
    t_regs();
    t_launch();
    t_sum();
    t_faults();
    conclude();
  end
endmodule
`default_nettype wire

// File: test/txs_mac_model.sv
/*
  Transmit MAC stand-in: takes the word stream and ends each frame.
  Assumes the block's clock and its synchronous reset.
*/
`default_nettype none
module txs_mac_model
  import txs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  slow,
  input  wire txs_pkg::txs_outcome_t fate,
  input  wire logic                  mac_valid,
  output logic                       mac_ready,
  input  wire txs_pkg::txs_word_t    mac_word,
  output logic                       mac_end,
  output txs_pkg::txs_outcome_t      mac_outcome,
  output int                         words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_q;
  // Slow stalls every other cycle; outcome is junk off the end pulse
  assign mac_ready   = !slow || tick_q;
  assign mac_outcome = mac_end ? fate : txs_outcome_t'(~fate);
  // End pulse follows the last word taken
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tick_q  <= 1'b0;
      mac_end <= 1'b0;
      words   <= 0;
    end
    else
    begin
      tick_q  <= !tick_q;
      mac_end <= mac_valid && mac_ready && mac_word.last;
      if (mac_valid && mac_ready)
        words <= words + 1;
    end
  end
endmodule
`default_nettype wire
